/* File: hciq_pkg.sv */
// ****************************************************************
// Shared constants of the host control and request block.
// ****************************************************************
package hciq_pkg;

  // ****************************************************************
  // Register offsets on the plain register port.
  // ****************************************************************
  localparam logic [1:0] HCIQ_OFF_MODE = 2'h0;
  localparam logic [1:0] HCIQ_OFF_LEVELS = 2'h1;
  localparam logic [1:0] HCIQ_OFF_PENDING = 2'h2;
  localparam logic [1:0] HCIQ_OFF_TX_CTL = 2'h3;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int HCIQ_MODE_ACK_POL = 0;
  localparam int HCIQ_MODE_FE_POL = 1;
  localparam int HCIQ_MODE_REQ_POL = 2;
  localparam int HCIQ_MODE_DMA = 3;
  localparam int HCIQ_MODE_AUTO_CLR = 4;
  localparam int HCIQ_MODE_HANDSHAKE = 5;
  localparam int HCIQ_MODE_TX_EN = 6;
  localparam int HCIQ_MODE_RX_EN = 7;
  localparam int HCIQ_LVL_TX_LO = 0;
  localparam int HCIQ_LVL_RX_LO = 2;
  localparam int HCIQ_LVL_FE_EN = 4;
  localparam int HCIQ_LVL_TX_EN = 5;
  localparam int HCIQ_LVL_RX_EN = 6;
  localparam int HCIQ_LVL_MASTER = 7;
  localparam int HCIQ_PEND_FE = 5;
  localparam int HCIQ_PEND_TX = 6;
  localparam int HCIQ_PEND_RX = 7;
  localparam int HCIQ_TXC_RTS = 1;

  // ****************************************************************
  // Values after reset and threshold decoding.
  // ****************************************************************
  localparam logic [7:0] HCIQ_MODE_RST = 8'h00;
  localparam logic [7:0] HCIQ_LEVELS_RST = 8'h00;
  localparam logic [2:0] HCIQ_LEVEL_DEFAULT = 3'h4;
  localparam logic [1:0] HCIQ_CODE_DEFAULT = 2'h0;
  localparam int HCIQ_SYNC_STAGES = 2;

endpackage

/* File: hciq_reset_sync.sv */
`timescale 1ns/1ps
// ****************************************************************
// Reset release synchroniser.
// ****************************************************************
module hciq_reset_sync
  import hciq_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  output logic reset_n_o
);

  // Two stages; only the last stage leaves the module.
  typedef struct packed {
    logic [HCIQ_SYNC_STAGES-1:0] stage;
  } hciq_rsync_t;

  hciq_rsync_t st;
  hciq_rsync_t next_st;

  // Shift a one in; assertion stays asynchronous, release is clocked.
  always_comb begin
    next_st = st;
    next_st.stage = {st.stage[HCIQ_SYNC_STAGES-2:0], 1'b1};
  end

  // Register the state.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reset_n_o = st.stage[HCIQ_SYNC_STAGES-1];

endmodule // hciq_reset_sync

/* File: hciq_level_detect.sv */
`timescale 1ns/1ps
// ****************************************************************
// Queue level threshold detector, one per queue.
// ****************************************************************
module hciq_level_detect
  import hciq_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [1:0] code_i,
  input wire logic [2:0] count_i,
  output logic flag_o
);

  typedef struct packed {
    logic flag;
  } hciq_lvl_t;

  hciq_lvl_t st;
  hciq_lvl_t next_st;
  logic [2:0] level;

  // Code 00 means four bytes, the other codes are the count itself.
  always_comb begin
    level = (code_i == HCIQ_CODE_DEFAULT) ? HCIQ_LEVEL_DEFAULT : {1'b0, code_i};
    next_st = st;
    // The flag drops as soon as the level no longer holds.
    next_st.flag = (count_i >= level);
  end

  // Register the state.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag_o = st.flag;

endmodule // hciq_level_detect

/* File: hciq_top.sv */
`timescale 1ns/1ps
// ****************************************************************
// Host control, interrupt and DMA request logic of the formatter.
// ****************************************************************
module hciq_top
  import hciq_pkg::*;
(
  // System clock and asynchronous active-low reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port.
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Queue occupancy from the datapath.
  input wire logic [2:0] tx_empty_count_i,
  input wire logic [2:0] rx_fill_count_i,
  // Receive frame end event and receiver status read strobe.
  input wire logic frame_end_event_i,
  input wire logic receiver_status_read_i,
  // Transmit frame closed, and abort after underrun finished.
  input wire logic tx_frame_done_i,
  input wire logic tx_abort_done_i,
  // Raw acknowledge pin and its normalised copy.
  input wire logic dma_acknowledge_i,
  output logic dma_ack_active_o,
  // Request pins towards host and DMA controller.
  output logic frame_end_output_o,
  output logic rx_request_out_o,
  output logic tx_request_out_o,
  output logic request_is_dma_o,
  // Modem handshake pins, both active low.
  input wire logic clear_to_send_n_i,
  output logic request_to_send_n_o,
  // Serial transmit data from the formatter and to the pin.
  input wire logic serial_tx_data_i,
  output logic txd_o,
  output logic txd_oe_o,
  // Clock and sample enables for the serial datapath.
  output logic transmit_clock_enable_o,
  output logic receive_sample_enable_o,
  output logic tx_permitted_o
);

  // ****************************************************************
  // State.
  // ****************************************************************

  // Block state held in one record; queue flags and reset stages sit in submodules.
  typedef struct packed {
    logic [7:0] mode_control;          // Write-only mode register.
    logic [7:0] request_enable_levels; // Write-only enables and levels.
    logic rts_bit;                     // Request-to-send control bit.
    logic frame_end_irq;               // Sticky frame end flag.
    logic [7:0] rdata;                 // Read data, valid one cycle.
    logic ack_active;                  // Normalised acknowledge.
    logic fe_out;                      // Frame end pin level.
    logic rx_out;                      // Receive request pin level.
    logic tx_out;                      // Transmit request pin level.
    logic dma_mode;                    // Request role copy.
    logic rts_n;                       // Request-to-send pin level.
    logic txd;                         // Serial output level.
    logic txd_oe;                      // Serial output enable.
    logic txclk_en;                    // Transmit clock enable.
    logic rx_en;                       // Receive sample enable.
    logic tx_ok;                       // Transmission permitted.
  } hciq_state_t;

  hciq_state_t st;
  hciq_state_t next_st;
  logic rst_n;                 // Synchronised reset copy.
  logic [1:0] queue_flag;      // Index 0 transmit, 1 receive.
  logic [1:0] queue_code [2];  // Threshold codes per queue.
  logic [2:0] queue_count [2]; // Occupancy per queue.

  // ****************************************************************
  // Reset release.
  // ****************************************************************

  // Assertion acts at once; release is clocked through two stages.
  hciq_reset_sync u_reset_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .reset_n_o(rst_n)
  );

  // ****************************************************************
  // Queue threshold detectors.
  // ****************************************************************

  // Codes come from the enable and level register.
  assign queue_code[0] = st.request_enable_levels[HCIQ_LVL_TX_LO +: 2];
  assign queue_code[1] = st.request_enable_levels[HCIQ_LVL_RX_LO +: 2];
  assign queue_count[0] = tx_empty_count_i;
  assign queue_count[1] = rx_fill_count_i;

  // One detector per queue; flags carry one cycle of latency.
  for (genvar q = 0; q < 2; q++) begin : g_queue
    hciq_level_detect u_level (
      .clk_i(clk_i),
      .reset_n_i(rst_n),
      .code_i(queue_code[q]),
      .count_i(queue_count[q]),
      .flag_o(queue_flag[q])
    );
  end

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************

  // All decisions of the block for the coming edge.
  always_comb begin
    logic handshake;
    logic auto_clr;
    logic master;
    logic fe_act;
    logic tx_act;
    logic rx_act;
    logic pend_read;
    logic [7:0] pend;
    // Locals start from a known value so no path leaves a latch.
    fe_act = 1'b0;
    tx_act = 1'b0;
    rx_act = 1'b0;
    pend = 8'h00;
    handshake = st.mode_control[HCIQ_MODE_HANDSHAKE];
    auto_clr = st.mode_control[HCIQ_MODE_AUTO_CLR];
    master = st.request_enable_levels[HCIQ_LVL_MASTER];
    pend_read = reg_rd_i && (reg_addr_i == HCIQ_OFF_PENDING);
    next_st = st;

    // Pending flags; reserved bits read as zero.
    pend = 8'h00;
    pend[HCIQ_PEND_FE] = st.frame_end_irq;
    pend[HCIQ_PEND_TX] = queue_flag[0];
    pend[HCIQ_PEND_RX] = queue_flag[1];

    // Register writes.
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        HCIQ_OFF_MODE: begin
          next_st.mode_control = reg_wdata_i;
        end
        HCIQ_OFF_LEVELS: begin
          next_st.request_enable_levels = reg_wdata_i;
        end
        HCIQ_OFF_TX_CTL: begin
          next_st.rts_bit = reg_wdata_i[HCIQ_TXC_RTS];
        end
        HCIQ_OFF_PENDING: begin
          // The flag register is read-only; writes are dropped.
        end
      endcase
    end

    // With auto-clear and handshake both set, hardware clears the request-to-send
    // bit at frame end or after the abort that follows an underrun. A software
    // write in the same cycle is the newer intent, so it wins.
    if (auto_clr && handshake && (tx_frame_done_i || tx_abort_done_i) &&
        !(reg_wr_i && (reg_addr_i == HCIQ_OFF_TX_CTL))) begin
      next_st.rts_bit = 1'b0;
    end

    // Frame end flag: a read clears it, a new event in that same
    // cycle sets it again so nothing is lost.
    if (pend_read || receiver_status_read_i) begin
      next_st.frame_end_irq = 1'b0;
    end
    if (frame_end_event_i) begin
      next_st.frame_end_irq = 1'b1;
    end

    // Read data stands only in the cycle after the strobe.
    next_st.rdata = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        HCIQ_OFF_PENDING: begin
          next_st.rdata = pend;
        end
        HCIQ_OFF_MODE, HCIQ_OFF_LEVELS, HCIQ_OFF_TX_CTL: begin
          // Write-only registers read as zero.
          next_st.rdata = 8'h00;
        end
      endcase
    end

    // Each request is flag AND own enable AND master enable.
    // Disabling only masks the pin; the flags stay untouched.
    fe_act = st.frame_end_irq && master &&
             st.request_enable_levels[HCIQ_LVL_FE_EN];
    tx_act = queue_flag[0] && master &&
             st.request_enable_levels[HCIQ_LVL_TX_EN];
    rx_act = queue_flag[1] && master &&
             st.request_enable_levels[HCIQ_LVL_RX_EN];

    // Map through polarity: bit clear gives an active-low pin.
    next_st.fe_out = st.mode_control[HCIQ_MODE_FE_POL] ? fe_act : !fe_act;
    next_st.tx_out = st.mode_control[HCIQ_MODE_REQ_POL] ? tx_act : !tx_act;
    next_st.rx_out = st.mode_control[HCIQ_MODE_REQ_POL] ? rx_act : !rx_act;

    // Role of the two request pins for the host side.
    next_st.dma_mode = st.mode_control[HCIQ_MODE_DMA];

    // Acknowledge pin normalised to active high.
    next_st.ack_active = st.mode_control[HCIQ_MODE_ACK_POL] ?
                         dma_acknowledge_i : !dma_acknowledge_i;

    // Request-to-send pin follows the bit only under handshake;
    // otherwise the pin rests inactive and the clear input is ignored.
    next_st.rts_n = handshake ? !st.rts_bit : 1'b1;

    // Sending is allowed only with the transmitter enabled and, under
    // handshake, both modem lines active.
    next_st.tx_ok = st.mode_control[HCIQ_MODE_TX_EN] &&
                    (!handshake || (st.rts_bit && !clear_to_send_n_i));

    // Serial output: data while permitted, else mark level.
    next_st.txd = next_st.tx_ok ? serial_tx_data_i : 1'b1;

    // Transmitter disabled floats the pin and gates the clock.
    next_st.txd_oe = st.mode_control[HCIQ_MODE_TX_EN];
    next_st.txclk_en = st.mode_control[HCIQ_MODE_TX_EN];

    // Receiver disabled only stops sampling; its state is kept.
    next_st.rx_en = st.mode_control[HCIQ_MODE_RX_EN];
  end

  // ****************************************************************
  // State register.
  // ****************************************************************

  // Reset gives inactive (high) pins because polarity bits reset to
  // zero, which makes every request pin active low.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.mode_control <= HCIQ_MODE_RST;
      st.request_enable_levels <= HCIQ_LEVELS_RST;
      st.fe_out <= 1'b1;
      st.rx_out <= 1'b1;
      st.tx_out <= 1'b1;
      st.rts_n <= 1'b1;
      st.txd <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs, each straight from the state register.
  // ****************************************************************

  assign reg_rdata_o = st.rdata;
  assign dma_ack_active_o = st.ack_active;
  assign frame_end_output_o = st.fe_out;
  assign rx_request_out_o = st.rx_out;
  assign tx_request_out_o = st.tx_out;
  assign request_is_dma_o = st.dma_mode;
  assign request_to_send_n_o = st.rts_n;
  assign txd_o = st.txd;
  assign txd_oe_o = st.txd_oe;
  assign transmit_clock_enable_o = st.txclk_en;
  assign receive_sample_enable_o = st.rx_en;
  assign tx_permitted_o = st.tx_ok;

endmodule // hciq_top

/* File: hciq_sva.sv */
`timescale 1ns/1ps
// ****************************************************************
// Port-level checker of the host control and request block.
// ****************************************************************
module hciq_check
  import hciq_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [2:0] tx_empty_count_i,
  input wire logic [2:0] rx_fill_count_i,
  input wire logic frame_end_event_i,
  input wire logic receiver_status_read_i,
  input wire logic tx_frame_done_i,
  input wire logic tx_abort_done_i,
  input wire logic dma_acknowledge_i,
  input wire logic dma_ack_active_o,
  input wire logic frame_end_output_o,
  input wire logic rx_request_out_o,
  input wire logic tx_request_out_o,
  input wire logic request_is_dma_o,
  input wire logic clear_to_send_n_i,
  input wire logic request_to_send_n_o,
  input wire logic txd_oe_o,
  input wire logic transmit_clock_enable_o,
  input wire logic receive_sample_enable_o,
  input wire logic tx_permitted_o
);
  logic [7:0] mode; // Shadow of the write-only mode register.
  logic [7:0] lvl; // Shadow of the enable and level register.
  logic [2:0] live_q; // Edges since reset release; the design's own reset lags by two.
  logic tx_hit, rx_hit; // Queue level conditions as the thresholds define them.
  wire live = live_q[2];
  function automatic logic [2:0] thr(input logic [1:0] c);
    return (c == 2'h0) ? HCIQ_LEVEL_DEFAULT : {1'b0, c};
  endfunction
  assign tx_hit = tx_empty_count_i >= thr(lvl[1:0]);
  assign rx_hit = rx_fill_count_i >= thr(lvl[3:2]);
  // Follow register writes so that the checks know the programmed mode.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode <= HCIQ_MODE_RST;
      lvl <= HCIQ_LEVELS_RST;
      live_q <= 3'h0;
    end else begin
      live_q <= {live_q[1:0], 1'b1};
      if (reg_wr_i && reg_addr_i == HCIQ_OFF_MODE) begin
        mode <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == HCIQ_OFF_LEVELS) begin
        lvl <= reg_wdata_i;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_ack_level: assert property (live |-> dma_ack_active_o == ($past(dma_acknowledge_i) ~^ $past(mode[0])))
    else $error("acknowledge level wrong");
  a_dma_role: assert property (live |-> request_is_dma_o == $past(mode[3]))
    else $error("request role wrong");
  a_port_enables: assert property (live |-> txd_oe_o == $past(mode[6])
    && transmit_clock_enable_o == $past(mode[6]) && receive_sample_enable_o == $past(mode[7]))
    else $error("serial enables wrong");
  a_hs_off: assert property (live && !$past(mode[5]) |-> request_to_send_n_o)
    else $error("handshake line active while disabled");
  a_tx_gate: assert property (live |-> tx_permitted_o == ($past(mode[6]) && (!$past(mode[5])
    || (!$past(clear_to_send_n_i) && !request_to_send_n_o))))
    else $error("transmit gating wrong");
  a_tx_pin: assert property (live |-> tx_request_out_o ==
    (($past(tx_hit, 2) && $past(lvl[5]) && $past(lvl[7])) ~^ $past(mode[2])))
    else $error("transmit request pin wrong");
  a_rx_pin: assert property (live |-> rx_request_out_o ==
    (($past(rx_hit, 2) && $past(lvl[6]) && $past(lvl[7])) ~^ $past(mode[2])))
    else $error("receive request pin wrong");
  a_fe_set: assert property (live && frame_end_event_i ##1 (lvl[4] && lvl[7] && !reg_wr_i)
    |=> frame_end_output_o == mode[1])
    else $error("frame end not signalled");
  a_fe_clear: assert property (live && !frame_end_event_i
    && ((reg_rd_i && reg_addr_i == HCIQ_OFF_PENDING) || receiver_status_read_i)
    ##1 (!frame_end_event_i && !reg_wr_i) |=> frame_end_output_o == !mode[1])
    else $error("frame end not cleared by read");
  a_pend_read: assert property (live && reg_rd_i && reg_addr_i == HCIQ_OFF_PENDING
    |=> reg_rdata_o[7:6] == {$past(rx_hit, 2), $past(tx_hit, 2)} && reg_rdata_o[4:0] == 5'h00)
    else $error("pending flags wrong");
  a_rts_follow: assert property (live && reg_wr_i && reg_addr_i == HCIQ_OFF_TX_CTL
    && mode[5] && !mode[4] |=> ##1 request_to_send_n_o == !$past(reg_wdata_i[1], 2))
    else $error("send request not following");
  a_auto_clear: assert property (live && mode[4] && mode[5] && (tx_frame_done_i || tx_abort_done_i)
    && !(reg_wr_i && reg_addr_i == HCIQ_OFF_TX_CTL) |=> ##1 request_to_send_n_o)
    else $error("send request not auto cleared");
  c_fe_pin: cover property (live && frame_end_event_i && lvl[4] && lvl[7]);
  c_abort_clear: cover property (live && mode[4] && mode[5] && tx_abort_done_i);
  c_dma_ack: cover property (live && request_is_dma_o && dma_ack_active_o);
endmodule // hciq_check

/* File: hciq_dma_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// DMA controller model: acknowledges an active transmit request.
// ****************************************************************
module hciq_dma_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic req_pin_i,
  input wire logic is_dma_i,
  input wire logic req_pol_i,
  input wire logic ack_pol_i,
  input wire logic slow_i,
  output logic ack_raw_o
);
  logic [1:0] pipe; // Request seen one and two cycles ago.
  // Track the request; a slow controller answers one cycle later.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pipe <= 2'h0;
    end else begin
      pipe <= {pipe[0], is_dma_i && (req_pin_i == req_pol_i)};
    end
  end
  // Drive the acknowledge at the level that software programmed.
  assign ack_raw_o = (slow_i ? pipe[1] : pipe[0]) ~^ ack_pol_i;
endmodule // hciq_dma_model

/* File: hciq_top_test.sv */
`timescale 1ns/1ps
module hciq_top_test;
  import hciq_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [1:0] reg_addr_i = 2'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, clear_to_send_n_i = 1'b0, serial_tx_data_i = 1'b0;
  logic [2:0] tx_empty_count_i = 3'h0, rx_fill_count_i = 3'h0;
  logic [3:0] ev = 4'h0; // One-cycle event pulses towards the block.
  logic ack_pol = 1'b0, req_pol = 1'b0, slow = 1'b1; // Settings mirrored into the DMA model.
  logic dma_acknowledge_i, dma_ack_active_o, frame_end_output_o, rx_request_out_o, tx_request_out_o, txd_o;
  logic request_is_dma_o, request_to_send_n_o, txd_oe_o, transmit_clock_enable_o, receive_sample_enable_o;
  logic tx_permitted_o;
  logic [7:0] reg_rdata_o, rd_val;
  int err_count = 0, n_checks = 0, thr;
  wire frame_end_event_i = ev[0];
  wire receiver_status_read_i = ev[1];
  wire tx_frame_done_i = ev[2];
  wire tx_abort_done_i = ev[3];
  wire [7:0] pins = {3'h0, frame_end_output_o, rx_request_out_o, tx_request_out_o, request_to_send_n_o, txd_o};
  wire [7:0] hs = {2'h0, receive_sample_enable_o, transmit_clock_enable_o, request_to_send_n_o, tx_permitted_o,
    txd_oe_o, txd_o};
  always #4 clk_i = ~clk_i;
  hciq_top dut (.clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .tx_empty_count_i, .rx_fill_count_i, .frame_end_event_i, .receiver_status_read_i, .tx_frame_done_i,
    .tx_abort_done_i, .dma_acknowledge_i, .dma_ack_active_o, .frame_end_output_o, .rx_request_out_o,
    .tx_request_out_o, .request_is_dma_o, .clear_to_send_n_i, .request_to_send_n_o, .serial_tx_data_i, .txd_o,
    .txd_oe_o, .transmit_clock_enable_o, .receive_sample_enable_o, .tx_permitted_o);
  hciq_dma_model partner (.clk_i, .reset_n_i, .req_pin_i(tx_request_out_o), .is_dma_i(request_is_dma_o),
    .req_pol_i(req_pol), .ack_pol_i(ack_pol), .slow_i(slow), .ack_raw_o(dma_acknowledge_i));
  // ****************************************************************
  // Access tasks and comparison.
  // ****************************************************************
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so take them then.
  task automatic rd(input logic [1:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 rd_val = reg_rdata_o;
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 4'h0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge clk_i);
    err_count++;
    print_verdict();
  end
  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    settle(2);
    rd(HCIQ_OFF_MODE);
    chk("mode read", rd_val, 8'h00);
    rd(HCIQ_OFF_PENDING);
    chk("pending", rd_val, 8'h00);
    chk("pins", pins, 8'h1F);
    $display("test reset done");
    // Both counts sit at the boundary, on opposite sides, for every code.
    for (int c = 0; c < 4; c++) begin
      wr(HCIQ_OFF_LEVELS, 8'(c * 5));
      thr = (c == 0) ? 4 : c;
      for (int k = -1; k < 1; k++) begin
        tx_empty_count_i <= 3'(thr - 1 - k);
        rx_fill_count_i <= 3'(thr + k);
        settle(3);
        rd(HCIQ_OFF_PENDING);
        chk("queue flags", rd_val, {k == 0, k != 0, 6'h00});
        chk("pins off", pins, 8'h1F);
      end
    end
    wr(HCIQ_OFF_PENDING, 8'hFF);
    rd(HCIQ_OFF_PENDING);
    chk("pending write", rd_val, 8'h80);
    rd(HCIQ_OFF_LEVELS);
    chk("levels read", rd_val, 8'h00);
    $display("test thresholds done");
    tx_empty_count_i <= 3'h1;
    rx_fill_count_i <= 3'h1;
    ack_pol <= 1'b1;
    req_pol <= 1'b1;
    wr(HCIQ_OFF_MODE, 8'h0F);
    wr(HCIQ_OFF_LEVELS, 8'hE5);
    settle(5);
    chk("req pins", pins, 8'h0F);
    chk("dma ack", {6'h00, request_is_dma_o, dma_ack_active_o}, 8'h03);
    wr(HCIQ_OFF_LEVELS, 8'hC5);
    settle(3);
    chk("tx off", pins, 8'h0B);
    rd(HCIQ_OFF_PENDING);
    chk("flags kept", rd_val, 8'hC0);
    wr(HCIQ_OFF_LEVELS, 8'h65);
    settle(3);
    chk("master off", pins, 8'h03);
    $display("test requests done");
    tx_empty_count_i <= 3'h0;
    rx_fill_count_i <= 3'h0;
    req_pol <= 1'b0;
    ack_pol <= 1'b0;
    wr(HCIQ_OFF_MODE, 8'h00);
    wr(HCIQ_OFF_LEVELS, 8'h90);
    pulse(4'h1);
    settle(2);
    chk("fe set", pins, 8'h0F);
    wr(HCIQ_OFF_LEVELS, 8'h80);
    settle(2);
    chk("fe masked", pins, 8'h1F);
    rd(HCIQ_OFF_PENDING);
    chk("fe sticky", rd_val, 8'h20);
    wr(HCIQ_OFF_LEVELS, 8'h90);
    settle(2);
    chk("fe read clear", pins, 8'h1F);
    pulse(4'h3);
    settle(2);
    chk("fe event wins", pins, 8'h0F);
    pulse(4'h2);
    settle(2);
    chk("fe status clear", pins, 8'h1F);
    $display("test frame end done");
    wr(HCIQ_OFF_MODE, 8'hE0);
    settle(2);
    chk("hs idle", hs, 8'h3B);
    wr(HCIQ_OFF_TX_CTL, 8'h02);
    settle(3);
    chk("hs send", hs, 8'h36);
    clear_to_send_n_i <= 1'b1;
    settle(3);
    chk("hs blocked", hs, 8'h33);
    clear_to_send_n_i <= 1'b0;
    // Frame spacing of at least one is assumed on the serial side here
    wr(HCIQ_OFF_MODE, 8'hF0);
    pulse(4'h4);
    settle(2);
    chk("auto clear", hs, 8'h3B);
    wr(HCIQ_OFF_TX_CTL, 8'h02);
    pulse(4'h8);
    settle(2);
    chk("abort clear", hs, 8'h3B);
    wr(HCIQ_OFF_MODE, 8'h40);
    clear_to_send_n_i <= 1'b1;
    wr(HCIQ_OFF_TX_CTL, 8'h02);
    settle(3);
    chk("hs off", hs, 8'h1E);
    wr(HCIQ_OFF_MODE, 8'h00);
    settle(3);
    chk("tx float", hs, 8'h09);
    $display("test handshake done");
    print_verdict();
  end
endmodule // hciq_top_test
bind hciq_top hciq_check u_check (.clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .tx_empty_count_i, .rx_fill_count_i, .frame_end_event_i, .receiver_status_read_i,
  .tx_frame_done_i, .tx_abort_done_i, .dma_acknowledge_i, .dma_ack_active_o, .frame_end_output_o,
  .rx_request_out_o, .tx_request_out_o, .request_is_dma_o, .clear_to_send_n_i, .request_to_send_n_o,
  .txd_oe_o, .transmit_clock_enable_o, .receive_sample_enable_o, .tx_permitted_o);
